// ---- timing_ctl_consts.vh ----
// Constants for the timing control block: register offsets, fields, resets and counts
// Notes on behaviour
// - 16-bit down-counter, mode from aux control bits
// - Counter sources: pin, tx A, tx B, ref/16
// - Timer sources: pin, pin/16, ref, ref/16
// - Timer square wave period twice preload
// - Square wave driven onto timer output pin
// - Timer output offered as 16X clock source
// - Timer preload changes apply next half cycle
// - Start loads preload and runs continuously
// - Start while running restarts timing cycle
// - Timer ready set each cycle, masked interrupt
// - Stop clears ready, but a same-cycle set wins; timer keeps running
// - Counter counts down, ready at zero
// - Counter wraps to FFFF until stopped
// - Counter pin high, low at terminal, reset on stop
// - Counter start restarts from stored preload
// - Counter preload used at next start only
// - Rate generator makes 13 rates per set at 16X
// - Aux control MSB picks rate set
// - Four input pins usable as 1X/16X clocks
// - Clock select: rx upper nibble, tx lower
`ifndef TIMING_CTL_CONSTS_VH
`define TIMING_CTL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_AUX_CTRL 4'h0
`define OFS_PRELOAD_HI 4'h1
`define OFS_PRELOAD_LO 4'h2
`define OFS_CMD_START 4'h3
`define OFS_CMD_STOP 4'h4
`define OFS_CSR_A 4'h5
`define OFS_CSR_B 4'h6
`define OFS_STATUS 4'h7
`define OFS_MASK 4'h8
`define OFS_COUNT_HI 4'h9
`define OFS_COUNT_LO 4'hA
`define OFS_EXTEND 4'hB

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ACR_SET_BIT 7
`define ACR_MODE_HI 6
`define ACR_MODE_LO 4
`define STAT_READY_BIT 3
`define ACR_RESET 8'h00
`define PRELOAD_RESET 8'h00
`define CSR_RESET 8'h00
`define MASK_RESET 8'h00

// ----------------------------------------
// Source selections and clock-select codes
// ----------------------------------------
`define SRC_C_PIN 3'h0
`define SRC_C_TXA 3'h1
`define SRC_C_TXB 3'h2
`define SRC_C_REF16 3'h3
`define SRC_T_PIN 3'h4
`define SRC_T_PIN16 3'h5
`define SRC_T_REF 3'h6
`define SRC_T_REF16 3'h7
`define CS_TIMER 4'hD
`define CS_EXT16 4'hE
`define CS_EXT1 4'hF
`define PRESCALE_DIV 4'hF

`endif

// ---- timing_ctl.v ----
// Timing control: counter/timer, rate generator and clock source selection
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "timing_ctl_consts.vh"

module timing_ctl #(
    parameter RATE_W = 16
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Pins and channel tx clocks (asynchronous)
    input wire ext_count_input_pin,
    input wire [3:0] ext_clk_pins,
    input wire chan_a_tx_clock,
    input wire chan_b_tx_clock,
    // Timer output pin control
    input wire timer_pin_enable,
    output reg timer_output_pin,
    // Status and interrupt request
    output wire ready_irq,
    // Selected channel clock enables: {rx_b, tx_b, rx_a, tx_a}
    output reg [3:0] chan_clk_tick,
    output reg [3:0] chan_clk_16x
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// Three stages; a change counts once stages two and three agree.
wire [6:0] async_in;
reg [6:0] s1_r;
reg [6:0] s2_r;
reg [6:0] s3_r;
reg [6:0] lvl_r;
reg [6:0] lvl_d_r;
assign async_in = {chan_b_tx_clock, chan_a_tx_clock, ext_clk_pins[3:1], ext_count_input_pin,
                   ext_clk_pins[0]};
integer i;
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        s1_r <= 7'h00;
        s2_r <= 7'h00;
        s3_r <= 7'h00;
        lvl_r <= 7'h00;
        lvl_d_r <= 7'h00;
    end else begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        for (i = 0; i < 7; i = i + 1) begin
            if (s2_r[i] == s3_r[i])
                lvl_r[i] <= s3_r[i];
        end
        lvl_d_r <= lvl_r;
    end
end
wire [6:0] rise = lvl_r & ~lvl_d_r;
// Bit 1 is the count pin; bits 0,2,3,4 are the four external clock pins
wire pin_rise = rise[1];
wire txa_rise = rise[5];
wire txb_rise = rise[6];
wire [3:0] ext_rise = {rise[4:2], rise[0]};

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] aux_control_reg;
reg [7:0] preload_upper_byte;
reg [7:0] preload_lower_byte;
reg [7:0] csr_a_r;
reg [7:0] csr_b_r;
reg [7:0] irq_mask_reg;
reg [3:0] extend_r;
reg ready_r;
reg running_r;
reg [15:0] count_r;
reg wave_r;
reg term_low_r;
reg [3:0] pre_ref_r;
reg [3:0] pre_pin_r;

wire [2:0] ct_mode = aux_control_reg[`ACR_MODE_HI:`ACR_MODE_LO];
wire timer_mode = ct_mode[2];
wire start_cmd = reg_wr && (reg_addr == `OFS_CMD_START);
wire stop_cmd = reg_wr && (reg_addr == `OFS_CMD_STOP);
wire [15:0] preload = {preload_upper_byte, preload_lower_byte};
wire [7:0] irq_status_reg = {4'h0, ready_r, 3'h0};

// ----------------------------------------
// Source prescalers and selection
// ----------------------------------------
// The reference clock is clk itself; its divide-by-16 is a free prescaler.
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pre_ref_r <= 4'h0;
        pre_pin_r <= 4'h0;
    end else begin
        pre_ref_r <= pre_ref_r + 4'h1;
        if (pin_rise)
            pre_pin_r <= pre_pin_r + 4'h1;
    end
end
wire ref16_tick = (pre_ref_r == `PRESCALE_DIV);
wire pin16_tick = pin_rise && (pre_pin_r == `PRESCALE_DIV);

reg src_tick;
always @* begin
    case (ct_mode)
        `SRC_C_PIN: src_tick = pin_rise;
        `SRC_C_TXA: src_tick = txa_rise;
        `SRC_C_TXB: src_tick = txb_rise;
        `SRC_C_REF16: src_tick = ref16_tick;
        `SRC_T_PIN: src_tick = pin_rise;
        `SRC_T_PIN16: src_tick = pin16_tick;
        `SRC_T_REF: src_tick = 1'b1;
        `SRC_T_REF16: src_tick = ref16_tick;
        default: src_tick = 1'b0;
    endcase
end

// ----------------------------------------
// Counter / timer core
// ----------------------------------------
// Timer reloads the preload at every half cycle, so host writes land there.
// A preload of zero is treated as one to keep the wave defined.
wire [15:0] reload = (preload == 16'h0000) ? 16'h0001 : preload;
wire half_end = (count_r == 16'h0001);
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        running_r <= 1'b0;
        count_r <= 16'h0000;
        wave_r <= 1'b1;
        term_low_r <= 1'b0;
        ready_r <= 1'b0;
    end else begin
        if (start_cmd) begin
            running_r <= 1'b1;
            count_r <= timer_mode ? reload : preload;
            wave_r <= 1'b1;
            term_low_r <= 1'b0;
        end else if (timer_mode) begin
            if (running_r && src_tick) begin
                if (half_end) begin
                    count_r <= reload;
                    wave_r <= ~wave_r;
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end
        end else begin
            if (stop_cmd) begin
                running_r <= 1'b0;
                term_low_r <= 1'b0;
            end else if (running_r && src_tick) begin
                count_r <= count_r - 16'h0001;
                if (half_end)
                    term_low_r <= 1'b1;
            end
        end
        // Ready: set wins over a same-cycle stop
        if (running_r && src_tick && !start_cmd && half_end &&
            (timer_mode ? !wave_r : 1'b1)) begin
            ready_r <= 1'b1;
        end else if (stop_cmd) begin
            ready_r <= 1'b0;
        end
    end
end

assign ready_irq = ready_r & irq_mask_reg[`STAT_READY_BIT];

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
        timer_output_pin <= 1'b1;
    else if (!timer_pin_enable)
        timer_output_pin <= 1'b1;
    else if (timer_mode)
        timer_output_pin <= wave_r;
    else
        timer_output_pin <= ~term_low_r;
end

// Timer edge, used as a 16X source by the clock selectors
reg wave_d_r;
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
        wave_d_r <= 1'b1;
    else
        wave_d_r <= wave_r;
end
wire timer_tick = timer_mode && running_r && wave_r && !wave_d_r;

// ----------------------------------------
// Rate generator
// ----------------------------------------
// One divider per code 0..12, reloaded from the set picked by the aux MSB.
// Divisors are parameters so any reference rate can be used.
parameter [16*RATE_W-1:0] DIV_SET0 = {16{16'h0010}};
parameter [16*RATE_W-1:0] DIV_SET1 = {16{16'h0020}};
reg [RATE_W-1:0] rate_cnt_r [0:12];
reg [12:0] rate_tick_r;
genvar g;
generate
    for (g = 0; g < 13; g = g + 1) begin : rate_div
        wire [RATE_W-1:0] div = aux_control_reg[`ACR_SET_BIT] ?
            DIV_SET1[g*RATE_W +: RATE_W] : DIV_SET0[g*RATE_W +: RATE_W];
        always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                rate_cnt_r[g] <= {RATE_W{1'b0}};
                rate_tick_r[g] <= 1'b0;
            end else if (rate_cnt_r[g] >= div - 1'b1) begin
                rate_cnt_r[g] <= {RATE_W{1'b0}};
                rate_tick_r[g] <= 1'b1;
            end else begin
                rate_cnt_r[g] <= rate_cnt_r[g] + 1'b1;
                rate_tick_r[g] <= 1'b0;
            end
        end
    end
endgenerate

// ----------------------------------------
// Clock source selectors
// ----------------------------------------
// Selector index: 0 tx A, 1 rx A, 2 tx B, 3 rx B; each has its own ext pin.
reg [3:0] sel_code [0:3];
always @* begin
    sel_code[0] = csr_a_r[3:0];
    sel_code[1] = csr_a_r[7:4];
    sel_code[2] = csr_b_r[3:0];
    sel_code[3] = csr_b_r[7:4];
end
integer k;
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        chan_clk_tick <= 4'h0;
        chan_clk_16x <= 4'h0;
    end else begin
        for (k = 0; k < 4; k = k + 1) begin
            if (sel_code[k] == `CS_EXT1) begin
                chan_clk_tick[k] <= ext_rise[k];
                chan_clk_16x[k] <= 1'b0;
            end else if (sel_code[k] == `CS_EXT16) begin
                chan_clk_tick[k] <= ext_rise[k];
                chan_clk_16x[k] <= 1'b1;
            end else if (sel_code[k] == `CS_TIMER) begin
                chan_clk_tick[k] <= timer_tick;
                chan_clk_16x[k] <= 1'b1;
            end else begin
                // Codes 0..12 pick the rate divider of the same number; extend bits unused
                chan_clk_tick[k] <= rate_tick_r[sel_code[k]];
                chan_clk_16x[k] <= 1'b1;
            end
        end
    end
end

// ----------------------------------------
// Register write and read
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        aux_control_reg <= `ACR_RESET;
        preload_upper_byte <= `PRELOAD_RESET;
        preload_lower_byte <= `PRELOAD_RESET;
        csr_a_r <= `CSR_RESET;
        csr_b_r <= `CSR_RESET;
        irq_mask_reg <= `MASK_RESET;
        extend_r <= 4'h0;
    end else if (reg_wr) begin
        case (reg_addr)
            `OFS_AUX_CTRL: aux_control_reg <= reg_wdata;
            `OFS_PRELOAD_HI: preload_upper_byte <= reg_wdata;
            `OFS_PRELOAD_LO: preload_lower_byte <= reg_wdata;
            `OFS_CSR_A: csr_a_r <= reg_wdata;
            `OFS_CSR_B: csr_b_r <= reg_wdata;
            `OFS_MASK: irq_mask_reg <= reg_wdata;
            `OFS_EXTEND: extend_r <= reg_wdata[3:0];
            default: extend_r <= extend_r;
        endcase
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
        reg_rdata <= 8'h00;
    else if (reg_rd) begin
        case (reg_addr)
            `OFS_AUX_CTRL: reg_rdata <= aux_control_reg;
            `OFS_PRELOAD_HI: reg_rdata <= preload_upper_byte;
            `OFS_PRELOAD_LO: reg_rdata <= preload_lower_byte;
            `OFS_CSR_A: reg_rdata <= csr_a_r;
            `OFS_CSR_B: reg_rdata <= csr_b_r;
            `OFS_STATUS: reg_rdata <= irq_status_reg;
            `OFS_MASK: reg_rdata <= irq_mask_reg;
            `OFS_COUNT_HI: reg_rdata <= count_r[15:8];
            `OFS_COUNT_LO: reg_rdata <= count_r[7:0];
            `OFS_EXTEND: reg_rdata <= {4'h0, extend_r};
            default: reg_rdata <= 8'h00;
        endcase
    end else
        reg_rdata <= 8'h00;
end

endmodule // timing_ctl

// ---- timing_ctl_properties.sv ----
// Port checker for the timing control block
`timescale 1ns/1ps
`include "timing_ctl_consts.vh"
module timing_ctl_properties (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Pins and status
    input wire timer_pin_enable,
    input wire timer_output_pin,
    input wire ready_irq,
    input wire [3:0] chan_clk_tick
);
reg [7:0] aux_r;
reg [7:0] mask_r;
reg [7:0] hi_r;
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
// ----------------------------------------
// Shadows of host writes
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        aux_r <= `ACR_RESET;
        mask_r <= `MASK_RESET;
        hi_r <= `PRELOAD_RESET;
    end else if (reg_wr) begin
        if (reg_addr == `OFS_AUX_CTRL) aux_r <= reg_wdata;
        if (reg_addr == `OFS_MASK) mask_r <= reg_wdata;
        if (reg_addr == `OFS_PRELOAD_HI) hi_r <= reg_wdata;
    end
end
sequence rd_at(a);
    reg_rd && reg_addr == a;
endsequence
sequence stop_cmd;
    reg_wr && reg_addr == `OFS_CMD_STOP;
endsequence
// ----------------------------------------
// Properties
// ----------------------------------------
aux_readback_a: assert property (
    rd_at(`OFS_AUX_CTRL) |=> reg_rdata == $past(aux_r)) else $error("aux readback wrong");
preload_readback_a: assert property (
    rd_at(`OFS_PRELOAD_HI) |=> reg_rdata == $past(hi_r)) else $error("preload readback wrong");
mask_gate_a: assert property (ready_irq |-> mask_r[3]) else $error("irq while masked");
status_match_a: assert property (
    rd_at(`OFS_STATUS) and mask_r[3] |=> reg_rdata[`STAT_READY_BIT] == $past(ready_irq))
    else $error("status ready differs from irq");
stop_clear_a: assert property (stop_cmd |=> !ready_irq) else $error("ready kept after stop");
pin_idle_a: assert property (
    !timer_pin_enable |=> timer_output_pin) else $error("pin low while not routed");
tick_single_a: assert property (
    chan_clk_tick[0] |=> !chan_clk_tick[0]) else $error("tick longer than one cycle");
stop_pin_high_a: assert property (
    stop_cmd ##0 (!aux_r[6] && timer_pin_enable) ##1 timer_pin_enable |=> timer_output_pin)
    else $error("counter pin low after stop");
endmodule // timing_ctl_properties
bind timing_ctl timing_ctl_properties chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_pin_enable(timer_pin_enable), .timer_output_pin(timer_output_pin),
    .ready_irq(ready_irq), .chan_clk_tick(chan_clk_tick));

// ---- ext_pulse_src.sv ----
// Model of the source that drives the external count pin
`timescale 1ns/1ps
module ext_pulse_src #(
    parameter HALF = 8
) (
    // Clock and control
    input wire clk,
    input wire en,
    // Pin
    output reg pin
);
integer cnt;
initial begin
    pin = 1'b0;
    cnt = 0;
end
// Rests low when off, so a stopped source leaves no stray edges
always @(posedge clk) begin
    if (!en) begin
        pin <= 1'b0;
        cnt <= 0;
    end else if (cnt == HALF - 1) begin
        pin <= ~pin;
        cnt <= 0;
    end else begin
        cnt <= cnt + 1;
    end
end
endmodule // ext_pulse_src

// ---- uart_timing_counter_timer_bench.sv ----
// Self-checking bench for the timing control block
`timescale 1ns/1ps
module uart_timing_counter_timer_bench;
reg clk, sys_rst, reg_wr, reg_rd, pin_en, src_en;
reg [3:0] reg_addr;
reg [7:0] reg_wdata;
wire [7:0] reg_rdata;
wire cnt_pin, timer_output_pin, ready_irq;
integer err_count, checks, n;
timing_ctl uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input_pin(cnt_pin),
    .ext_clk_pins(4'h0), .chan_a_tx_clock(1'b0), .chan_b_tx_clock(1'b0),
    .timer_pin_enable(pin_en), .timer_output_pin(timer_output_pin), .ready_irq(ready_irq),
    .chan_clk_tick(), .chan_clk_16x());
ext_pulse_src src (.clk(clk), .en(src_en), .pin(cnt_pin));
always #12.5 clk = ~clk;
task chk(input [127:0] what, input [7:0] exp, input [7:0] got);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s: expected %0h, seen %0h", what, exp, got);
        end
    end
endtask
task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
endtask
task rd(input [3:0] a, input [7:0] m, input [7:0] exp);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata & m);
    end
endtask
task idle(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
endtask
// Bounded wait for the ready interrupt
task wait_irq(input integer lim);
    begin
        n = 0;
        while (ready_irq !== 1'b1 && n < lim) begin
            idle(1);
            n = n + 1;
        end
    end
endtask
// Length of the next full high half of the output pin, in cycles
// A half already in progress is skipped, so the idle-high pin before start never counts
task half;
    begin
        n = 0;
        while (timer_output_pin === 1'b1 && n < 200) begin
            idle(1);
            n = n + 1;
        end
        n = 0;
        while (timer_output_pin !== 1'b1 && n < 200) begin
            idle(1);
            n = n + 1;
        end
        n = 0;
        while (timer_output_pin === 1'b1 && n < 200) begin
            idle(1);
            n = n + 1;
        end
    end
endtask
task t_regs;
    begin
        chk("idle pin", 8'h01, {7'h00, timer_output_pin});
        rd(4'h0, 8'hFF, 8'h00);
        rd(4'hC, 8'hFF, 8'h00);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'hFF, 8'h80);
        wr(4'h1, 8'hA5);
        rd(4'h1, 8'hFF, 8'hA5);
    end
endtask
task t_timer;
    begin
        wr(4'h8, 8'h08);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h05);
        wr(4'h0, 8'h60);
        @(posedge clk) pin_en <= 1'b1;
        wr(4'h3, 8'h00);
        half;
        chk("high half", 8'd5, n[7:0]);
        half;
        chk("second half", 8'd5, n[7:0]);
        chk("ready", 8'h01, {7'h00, ready_irq});
        wr(4'h2, 8'h07);
        half;
        half;
        chk("new half", 8'd7, n[7:0]);
        wr(4'h4, 8'h00);
        rd(4'h7, 8'h08, 8'h00);
        half;
        chk("half after stop", 8'd7, n[7:0]);
    end
endtask
task t_counter;
    begin
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'h2, 8'h03);
        @(posedge clk) src_en <= 1'b1;
        wr(4'h3, 8'h00);
        idle(30);
        chk("pin early", 8'h01, {7'h00, timer_output_pin});
        chk("irq early", 8'h00, {7'h00, ready_irq});
        wait_irq(40);
        chk("irq at zero", 8'h01, {7'h00, ready_irq});
        // The pin is registered one cycle behind the ready flag
        idle(1);
        chk("pin at zero", 8'h00, {7'h00, timer_output_pin});
        idle(20);
        rd(4'h9, 8'hFF, 8'hFF);
        wr(4'h4, 8'h00);
        idle(3);
        chk("pin stopped", 8'h01, {7'h00, timer_output_pin});
        chk("irq stopped", 8'h00, {7'h00, ready_irq});
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h00);
        wait_irq(25);
        chk("irq reload", 8'h01, {7'h00, ready_irq});
        wr(4'h8, 8'h00);
        idle(1);
        chk("irq masked", 8'h00, {7'h00, ready_irq});
    end
endtask
task complete_run;
    begin
        $display("mismatches %0d, comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
initial begin
    #100000;
    err_count = err_count + 1;
    complete_run;
end
initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, pin_en, src_en} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    err_count = 0;
    checks = 0;
    idle(4);
    sys_rst = 1'b0;
    t_regs;
    t_timer;
    t_counter;
    complete_run;
end
endmodule // uart_timing_counter_timer_bench
